// *** dccam_pkg.sv ***
// Package for the comparator C address-match block: register map, fields and carrier types
package dccam_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 6;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PAGE_EXT = 6'h25;
  localparam logic [IDX_W-1:0] IDX_ADDR_HIGH = 6'h26;
  localparam logic [IDX_W-1:0] IDX_ADDR_LOW = 6'h27;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h28;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h29;

  // Page extension fields
  localparam int PAGING_SELECT_MSB = 7;
  localparam int PAGING_SELECT_LSB = 6;
  localparam int EXT_W = 6;

  // Control and status fields
  localparam int BRK_EN_BIT = 3;
  localparam int STAT_LIVE_BIT = 0;
  localparam int STAT_SEEN_BIT = 1;
  localparam int STAT_MODE_BIT = 2;

  localparam logic [7:0] PAGE_EXT_RST = 8'h00;
  localparam logic [7:0] ADDR_HIGH_RST = 8'h00;
  localparam logic [7:0] ADDR_LOW_RST = 8'h00;
  localparam logic BRK_EN_RST = 1'b0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {PM_NORMAL, PM_PROGRAM} dccam_page_mode_t;

  typedef struct packed {
    logic [7:0] program_page_index;
    logic [15:0] core_address_bus;
  } dccam_core_bus_t;

  typedef struct packed {
    logic [7:0] page_ext;
    logic [15:0] compare;
  } dccam_cmp_cfg_t;

  // The upper paging-select bit selects unimplemented paging, so only the low bit counts
  function automatic dccam_page_mode_t dccam_eff_mode(input logic [7:0] page_ext);
    return page_ext[PAGING_SELECT_LSB] ? PM_PROGRAM : PM_NORMAL;
  endfunction

endpackage

// *** dccam_comparator.sv ***
// Address comparator with optional program-page extension
`timescale 1ns/1ps
module dccam_comparator
  import dccam_pkg::*;
(
  input wire dccam_cmp_cfg_t cfg,
  input wire dccam_core_bus_t core,
  output logic hit
);

  logic [21:0] expanded_address_bus;
  logic [7:0] high_ref;
  logic ext_ok;
  dccam_page_mode_t mode;

  always_comb
  begin
    mode = dccam_eff_mode(cfg.page_ext);
    // Page index replaces address bits 21:14 of the expanded bus
    expanded_address_bus = {core.program_page_index, core.core_address_bus[13:0]};
    unique case (mode)
      PM_NORMAL:
      begin
        high_ref = core.core_address_bus[15:8];
        ext_ok = 1'b1;
      end
      PM_PROGRAM:
      begin
        high_ref = {expanded_address_bus[15:14], core.core_address_bus[13:8]};
        ext_ok = cfg.page_ext[EXT_W-1:0] == expanded_address_bus[21:16];
      end
    endcase
    hit = ext_ok && (high_ref == cfg.compare[15:8])
      && (core.core_address_bus[7:0] == cfg.compare[7:0]);
  end

endmodule // dccam_comparator

// *** dccam_top.sv ***
// Comparator C address match with AXI4-Lite register access
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dccam_top
  import dccam_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dccam_core_bus_t core,
  input wire logic arm_pulse,
  input wire logic loop_capture_mode,
  output logic comp_c_match,
  output logic comp_c_break
);

  logic [7:0] page_ext_reg, addr_high_reg, addr_low_reg;
  logic brk_en_reg, seen_reg, match_reg, break_reg, aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic aw_take, w_take, ar_take, do_write, wr_lane0, arm_clear, cmp_hit;
  logic [IDX_W-1:0] wr_idx, rd_idx;
  dccam_cmp_cfg_t cfg;

  function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
    return idx >= IDX_PAGE_EXT && idx <= IDX_STATUS;
  endfunction

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = aw_held_reg && w_held_reg;
  assign wr_idx = awaddr_reg[IDX_LSB +: IDX_W];
  assign rd_idx = s_axi_araddr[IDX_LSB +: IDX_W];
  // Registers are eight bits wide and live in byte lane 0
  assign wr_lane0 = do_write && wstrb_reg[0];
  assign arm_clear = arm_pulse && loop_capture_mode;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign comp_c_match = match_reg;
  assign comp_c_break = break_reg;
  assign cfg = '{page_ext: page_ext_reg, compare: {addr_high_reg, addr_low_reg}};

  // Address and data are caught independently so the master may offer them in any order
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= '0;
    end
    else if (aw_take)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      w_held_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end
    else if (w_take)
    begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      page_ext_reg <= PAGE_EXT_RST;
    else if (wr_lane0 && wr_idx == IDX_PAGE_EXT)
      page_ext_reg <= wdata_reg[7:0];
  end

  // Arming in loop capture wins over a software write in the same cycle
  always_ff @(posedge clock)
  begin
    if (sys_rst || arm_clear)
    begin
      addr_high_reg <= ADDR_HIGH_RST;
      addr_low_reg <= ADDR_LOW_RST;
    end
    else if (wr_lane0)
    begin
      if (wr_idx == IDX_ADDR_HIGH)
        addr_high_reg <= wdata_reg[7:0];
      if (wr_idx == IDX_ADDR_LOW)
        addr_low_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst || arm_clear)
      brk_en_reg <= BRK_EN_RST;
    else if (wr_lane0 && wr_idx == IDX_CTRL)
      brk_en_reg <= wdata_reg[BRK_EN_BIT];
  end

  dccam_comparator u_cmp (
    .cfg(cfg),
    .core(core),
    .hit(cmp_hit)
  );

  // Match is not gated by breakpoint or trace mode, so it serves either one
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      match_reg <= 1'b0;
      break_reg <= 1'b0;
    end
    else
    begin
      match_reg <= cmp_hit;
      break_reg <= cmp_hit && brk_en_reg;
    end
  end

  // Sticky match flag: a new hit beats a clear written in the same cycle
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      seen_reg <= 1'b0;
    else if (cmp_hit)
      seen_reg <= 1'b1;
    else if (wr_lane0 && wr_idx == IDX_STATUS && wdata_reg[STAT_SEEN_BIT])
      seen_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end
    else if (ar_take)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= '0;
      unique case (rd_idx)
        IDX_PAGE_EXT: rdata_reg[7:0] <= page_ext_reg;
        IDX_ADDR_HIGH: rdata_reg[7:0] <= addr_high_reg;
        IDX_ADDR_LOW: rdata_reg[7:0] <= addr_low_reg;
        IDX_CTRL: rdata_reg[BRK_EN_BIT] <= brk_en_reg;
        IDX_STATUS:
        begin
          rdata_reg[STAT_LIVE_BIT] <= match_reg;
          rdata_reg[STAT_SEEN_BIT] <= seen_reg;
          rdata_reg[STAT_MODE_BIT] <= dccam_eff_mode(page_ext_reg) == PM_PROGRAM;
        end
        default: rdata_reg <= '0;
      endcase
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  sequence s_arm_loop;
    arm_pulse && loop_capture_mode;
  endsequence

  sequence s_write_offered;
    aw_take && w_take;
  endsequence

  property p_arm_clears_compare;
    @(posedge clock) disable iff (sys_rst)
    s_arm_loop |=> addr_high_reg == 8'h00 && addr_low_reg == 8'h00;
  endproperty
  a_arm_clears_compare: assert property (p_arm_clears_compare)
    else $error("compare value not cleared on loop arming");

  property p_arm_clears_enable;
    @(posedge clock) disable iff (sys_rst)
    s_arm_loop |=> !brk_en_reg ##1 !comp_c_break;
  endproperty
  a_arm_clears_enable: assert property (p_arm_clears_enable)
    else $error("break enable survives loop arming");

  property p_break_gated;
    @(posedge clock) disable iff (sys_rst)
    comp_c_break |-> comp_c_match && $past(brk_en_reg);
  endproperty
  a_break_gated: assert property (p_break_gated)
    else $error("break raised without enable or match");

  property p_normal_match;
    @(posedge clock) disable iff (sys_rst)
    !page_ext_reg[PAGING_SELECT_LSB] && core.core_address_bus == {addr_high_reg, addr_low_reg} |=> comp_c_match;
  endproperty
  a_normal_match: assert property (p_normal_match)
    else $error("unpaged address equal to compare value missed");

  property p_top_select_ignored;
    @(posedge clock) disable iff (sys_rst)
    page_ext_reg[PAGING_SELECT_MSB] && page_ext_reg[PAGING_SELECT_LSB]
      && core.program_page_index[7:2] != page_ext_reg[EXT_W-1:0] |=> !comp_c_match;
  endproperty
  a_top_select_ignored: assert property (p_top_select_ignored)
    else $error("select 11 did not act as program paging");

  property p_program_match;
    @(posedge clock) disable iff (sys_rst)
    page_ext_reg[PAGING_SELECT_LSB] && core.program_page_index[7:2] == page_ext_reg[EXT_W-1:0]
      && {core.program_page_index[1:0], core.core_address_bus[13:0]} == {addr_high_reg, addr_low_reg}
      |=> comp_c_match;
  endproperty
  a_program_match: assert property (p_program_match)
    else $error("program paged match missed");

  property p_low_mismatch;
    @(posedge clock) disable iff (sys_rst)
    core.core_address_bus[7:0] != addr_low_reg |=> !comp_c_match;
  endproperty
  a_low_mismatch: assert property (p_low_mismatch)
    else $error("match despite differing low address byte");

  property p_low_write;
    @(posedge clock) disable iff (sys_rst)
    wr_lane0 && wr_idx == IDX_ADDR_LOW && !arm_clear |=> addr_low_reg == $past(wdata_reg[7:0]);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("compare low byte write lost");

  property p_write_response;
    @(posedge clock) disable iff (sys_rst)
    s_write_offered |-> ##1 !bvalid_reg ##1 bvalid_reg;
  endproperty
  a_write_response: assert property (p_write_response)
    else $error("write response not two cycles after acceptance");

endmodule // dccam_top

// *** dccam_core_model.sv ***
// Core-side model: drives address bus and program page index on the system clock
`timescale 1ns/1ps
module dccam_core_model
  import dccam_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] page_req,
  input wire logic [15:0] addr_req,
  output dccam_core_bus_t core
);
  // Page and address launch together after an edge, so the comparator never sees a half-updated bus
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      core <= '0;
    end
    else
    begin
      core.program_page_index <= page_req;
      core.core_address_bus <= addr_req;
    end
  end
endmodule // dccam_core_model

// *** test_dccam_top.sv ***
// Self-checking bench for the comparator C address-match block
`timescale 1ns/1ps
module test_dccam_top;
  import dccam_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = '0, araddr = '0, page_req = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, comp_c_match, comp_c_break;
  logic [1:0] bresp, rresp;
  logic [15:0] addr_req = '0;
  logic arm_pulse = 0, loop_capture_mode = 0;
  dccam_core_bus_t core;
  int num_errors = 0, cmp_count = 0;
  // Each entry: page_ext, page index, address; compare value stays c5c3
  logic [31:0] tbl [9] = '{32'h0000c5c3, 32'h00ffc5c2, 32'h805545c3, 32'h8012c5c3, 32'h4b2f05c3,
    32'hcb2b05c3, 32'h4b2ec5c3, 32'hcb2fc5c3, 32'h4b2f05c1};

  always #12.5 clock = ~clock;

  dccam_core_model dccam_core_model_inst (.clock(clock), .sys_rst(sys_rst), .page_req(page_req),
    .addr_req(addr_req), .core(core));
  dccam_top dccam_top_inst (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core(core), .arm_pulse(arm_pulse),
    .loop_capture_mode(loop_capture_mode), .comp_c_match(comp_c_match), .comp_c_break(comp_c_break));

  task automatic results;
    if (num_errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      #1;
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid & bready;
      r = bresp;
      @(posedge clock);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) break;
    end
    bready <= 1'b0;
    if (n == 50)
    begin
      num_errors++;
      results;
    end
    check({30'h0, r}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, r_t;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      #1;
      ar_t = arvalid & arready;
      r_t = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) break;
    end
    rready <= 1'b0;
    if (n == 50)
    begin
      num_errors++;
      results;
    end
    check(d, ed);
    check({30'h0, r}, {30'h0, er});
  endtask

  function automatic logic exp_hit(input logic [7:0] pe, input logic [15:0] c, input logic [7:0] pg,
    input logic [15:0] a);
    if (pe[6])
      return pe[5:0] == pg[7:2] && c == {pg[1:0], a[13:0]};
    return c == a;
  endfunction

  // Sweep the case table with break enable off, then on
  task automatic cmp_pass(input logic en);
    logic [31:0] t;
    logic h;
    axi_wr(8'ha0, {4'h0, en, 3'h0}, RESP_OKAY);
    for (int i = 0; i < 9; i++)
    begin
      t = tbl[i];
      axi_wr(8'h94, t[31:24], RESP_OKAY);
      @(posedge clock);
      page_req <= t[23:16];
      addr_req <= t[15:0];
      repeat (3) @(posedge clock);
      #1;
      h = exp_hit(t[31:24], 16'hc5c3, t[23:16], t[15:0]);
      check({31'h0, comp_c_match}, {31'h0, h});
      check({31'h0, comp_c_break}, {31'h0, h & en});
    end
  endtask

  task automatic arm_chk(input logic lp);
    @(posedge clock);
    arm_pulse <= 1'b1;
    loop_capture_mode <= lp;
    @(posedge clock);
    arm_pulse <= 1'b0;
    axi_rd(8'h98, lp ? 32'h0 : 32'hc5, RESP_OKAY);
    axi_rd(8'h9c, lp ? 32'h0 : 32'hc3, RESP_OKAY);
    axi_rd(8'ha0, lp ? 32'h0 : 32'h8, RESP_OKAY);
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    axi_rd(8'h94, 32'h0, RESP_OKAY);
    axi_rd(8'h98, 32'h0, RESP_OKAY);
    axi_rd(8'h00, 32'h0, RESP_SLVERR);
    axi_wr(8'hfc, 8'h11, RESP_SLVERR);
    axi_wr(8'h98, 8'hc5, RESP_OKAY);
    axi_wr(8'h9c, 8'hc3, RESP_OKAY);
    axi_rd(8'h9c, 32'hc3, RESP_OKAY);
    cmp_pass(1'b0);
    cmp_pass(1'b1);
    // Status after the sweep: no live match, sticky seen set, program paging selected
    axi_rd(8'ha4, 32'h6, RESP_OKAY);
    axi_wr(8'ha4, 8'h02, RESP_OKAY);
    axi_rd(8'ha4, 32'h4, RESP_OKAY);
    arm_chk(1'b0);
    arm_chk(1'b1);
    results;
  end
endmodule // test_dccam_top
